/* skip_exec.sv */
// Execution sequencer for the increment and bit-test skip instructions.
// Contract
// - Increment-memory op adds one to addressed byte and writes it back.
// - On skip, discard next instruction with dummy cycle; three cycles.
// - Non-zero increment result means no skip; next instruction runs.
// - Increment-to-accumulator op loads byte plus one; memory untouched.
// - Increment-to-accumulator op skips exactly when new value is zero.
// - Bit-test op skips when the selected memory bit is one.
`include "skip_exec_defines.svh"
module skip_exec #(
  parameter int DW = `DATA_W
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic i_START,
  input wire skip_exec_pkg::op_e i_OP,
  input wire logic [`BIT_SEL_W-1:0] i_BIT_SEL,
  input wire logic [DW-1:0] i_MEM_RDATA,
  output logic o_BUSY,
  output logic o_MEM_WE,
  output logic [DW-1:0] o_MEM_WDATA,
  output logic o_ACC_WE,
  output logic [DW-1:0] o_ACC_WDATA,
  output logic o_DISCARD,
  output logic o_DONE,
  output logic o_FLAGS_WE
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} state_e;
  state_e state_ff;
  state_e nxt_state;
  skip_exec_pkg::op_e op_ff;
  logic [`BIT_SEL_W-1:0] bit_ff;
  logic [DW-1:0] result;
  logic skip;

  skip_cond_unit #(.DW(DW)) u_cond (
    .i_op(op_ff),
    .i_mem_data(i_MEM_RDATA),
    .i_bit_sel(bit_ff),
    .o_result(result),
    .o_skip(skip)
  );

  // Cycle one latches the op; cycle two reads memory and decides; a skip
  // adds a third, dummy cycle while the following word is fetched.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_START) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = skip ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      op_ff <= skip_exec_pkg::OP_NONE;
      bit_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && i_START) begin
        op_ff <= i_OP;
        bit_ff <= i_BIT_SEL;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire in_exec = (state_ff == ST_EXEC);
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      o_BUSY <= 1'b0;
      o_MEM_WE <= 1'b0;
      o_MEM_WDATA <= '0;
      o_ACC_WE <= 1'b0;
      o_ACC_WDATA <= '0;
      o_DISCARD <= 1'b0;
      o_DONE <= 1'b0;
      o_FLAGS_WE <= 1'b0;
    end else begin
      o_BUSY <= (nxt_state != ST_IDLE);
      o_MEM_WE <= in_exec &&
        op_ff == skip_exec_pkg::OP_INC_MEM_SKIP_ZERO;
      o_ACC_WE <= in_exec &&
        op_ff == skip_exec_pkg::OP_INC_TO_ACC_SKIP_ZERO;
      if (in_exec) begin
        o_MEM_WDATA <= result;
        o_ACC_WDATA <= result;
      end
      o_DISCARD <= in_exec && skip;
      o_DONE <= (in_exec && !skip) || state_ff == ST_DUMMY;
      // Flags never change here, so the status write is held off.
      o_FLAGS_WE <= 1'b0;
    end
  end
endmodule // skip_exec

/* skip_exec_defines.svh */
// Timing counts and field widths for the conditional skip executor.
`ifndef SKIP_EXEC_DEFINES_SVH
`define SKIP_EXEC_DEFINES_SVH
`define DATA_W 8
`define BIT_SEL_W 3
`define NOSKIP_CYCLES 2
`define SKIP_CYCLES 3
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00
`endif

/* skip_exec_pkg.sv */
// Types shared by the conditional skip executor.
package skip_exec_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_INC_MEM_SKIP_ZERO,
    OP_INC_TO_ACC_SKIP_ZERO,
    OP_SKIP_IF_BIT_SET
  } op_e;
endpackage

/* skip_cond_unit.sv */
// Combinational result and skip decision for the three skip instructions.
`include "skip_exec_defines.svh"
module skip_cond_unit #(
  parameter int DW = `DATA_W
) (
  input wire skip_exec_pkg::op_e i_op,
  input wire logic [DW-1:0] i_mem_data,
  input wire logic [`BIT_SEL_W-1:0] i_bit_sel,
  output logic [DW-1:0] o_result,
  output logic o_skip
);
  always_comb begin
    o_result = i_mem_data + DW'(`BYTE_ONE);
    o_skip = 1'b0;
    case (i_op)
      skip_exec_pkg::OP_INC_MEM_SKIP_ZERO: begin
        o_skip = (o_result == DW'(`BYTE_ZERO));
      end
      skip_exec_pkg::OP_INC_TO_ACC_SKIP_ZERO: begin
        o_skip = (o_result == DW'(`BYTE_ZERO));
      end
      skip_exec_pkg::OP_SKIP_IF_BIT_SET: begin
        o_skip = i_mem_data[i_bit_sel];
      end
      default: begin
        o_skip = 1'b0;
      end
    endcase
  end
endmodule // skip_cond_unit

/* skip_exec_monitor.sv */
// Port checker for the skip executor.
module skip_exec_monitor #(parameter int DW = 8) (
  input wire logic I_CLK_SYS, I_NRST, i_START,
  input wire skip_exec_pkg::op_e i_OP,
  input wire logic [2:0] i_BIT_SEL,
  input wire logic [DW-1:0] i_MEM_RDATA, o_MEM_WDATA, o_ACC_WDATA,
  input wire logic o_BUSY, o_MEM_WE, o_ACC_WE, o_DISCARD, o_DONE,
  input wire logic o_FLAGS_WE
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  sequence s_tail; !o_DONE ##1 o_DONE; endsequence
  a_mem_inc: assert property (o_MEM_WE |->
    o_MEM_WDATA == $past(i_MEM_RDATA) + 1'b1 && !o_ACC_WE) else $error("w");
  a_acc_inc: assert property (o_ACC_WE |->
    o_ACC_WDATA == $past(i_MEM_RDATA) + 1'b1) else $error("a");
  a_acc_skip: assert property (o_ACC_WE |->
    o_DISCARD == (o_ACC_WDATA == 0)) else $error("as");
  a_mem_skip: assert property (o_MEM_WE |->
    o_DISCARD == (o_MEM_WDATA == 0)) else $error("ms");
  a_skip_len: assert property (o_DISCARD |-> s_tail)
    else $error("len");
  a_bit_skip: assert property (i_START && !o_BUSY &&
    i_OP == skip_exec_pkg::OP_SKIP_IF_BIT_SET |=> ##1 o_DISCARD ==
    ((($past(i_MEM_RDATA) >> $past(i_BIT_SEL, 2)) & 1) != 0)) else $error("b");
  a_no_flags: assert property (!o_FLAGS_WE) else $error("f");
endmodule // skip_exec_monitor
bind skip_exec skip_exec_monitor #(.DW(DW)) u_mon (.*);

/* skip_exec_bench.sv */
// Self-checking bench for the skip executor.
module skip_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: mismatch", $time); end end
  logic clk = 0, nrst = 0, start = 0, busy, mwe, awe, disc, done, fwe;
  logic [2:0] sel = 0;
  logic [7:0] rd = 0, mwd, awd;
  logic [31:0] r = 32'h5212;
  skip_exec_pkg::op_e op = skip_exec_pkg::OP_NONE;
  int failures = 0, cmp_count = 0, cyc = 0;
  skip_exec u_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .i_START(start),
    .i_OP(op), .i_BIT_SEL(sel), .i_MEM_RDATA(rd), .o_BUSY(busy),
    .o_MEM_WE(mwe), .o_MEM_WDATA(mwd), .o_ACC_WE(awe), .o_ACC_WDATA(awd),
    .o_DISCARD(disc), .o_DONE(done), .o_FLAGS_WE(fwe));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic skips(logic [1:0] o, logic [2:0] b, logic [7:0] d);
    return o == 2'h3 ? d[b] : o != 2'h0 && d == 8'hFF;
  endfunction
  task automatic end_of_test;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run(logic [1:0] o, logic [2:0] b, logic [7:0] d);
    int n = 2;
    start = 1;
    op = skip_exec_pkg::op_e'(o);
    sel = b;
    @(negedge clk) start = 0;
    rd = d;
    @(negedge clk) rd = ~d;
    `CHK(mwe, o == 2'h1)
    `CHK(awe, o == 2'h2)
    if (o == 2'h1) `CHK(mwd, d + 8'h01)
    if (o == 2'h2) `CHK(awd, d + 8'h01)
    `CHK(disc, skips(o, b, d))
    `CHK(busy, skips(o, b, d))
    `CHK(fwe, 1'b0)
    while (done !== 1'b1 && n < 6) begin
      @(negedge clk) n++;
    end
    `CHK(n, skips(o, b, d) ? 3 : 2)
    @(negedge clk);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 8; k++) run(k[1:0], 3'(k * 5), k[2] ? 8'hFE : 8'hFF);
    run(2'h3, 3'h0, 8'hFE);
    for (int k = 0; k < 40; k++) begin
      r = lfsr(r);
      run(r[1:0], r[4:2], r[5] ? 8'hFF : r[13:6]);
    end
    end_of_test;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test;
    end
  end
endmodule // skip_exec_bench
